// ### src/dcfo_fifo.sv
// dual clock 36-bit fifo with offset load, flags and ahb-lite status registers
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "dcfo_defines.svh"
// Summary of operation
// (RULE1) master reset lasts four write-side and four read-side clock edges
// (RULE2) master reset may assert and release at any moment
// (RULE3) reset clears pointers, ready flags low, near-empty low, near-full high
// (RULE4) reset drives both mailbox flags high
// (RULE5) input-ready rises at least two write-side edges after reset
// (RULE6) the host resets the device after power-up before writing
// (RULE7) flag selects at reset release choose serial, 64, 8 or parallel
// (RULE8) preset modes load both offsets, input-ready after two write edges
// (RULE9) parallel mode: first two writes load near-full then near-empty offset
// (RULE10) parallel offset value comes from the low write-port data bits
// (RULE11) host keeps offsets between 1 and the depth-dependent limit
// (RULE12) serial mode shifts one bit per write edge while enable low
// (RULE13) serial programming takes twice the offset width in bits
// (RULE14) serial stream: near-full offset msb first, near-empty lsb last
// (RULE15) serial mode: input-ready low until last bit, then rises
// (RULE16) write-port bus driven only when select and direction both low
// (RULE17) qualified port-a write stores the word in memory
// (RULE18) read-port bus driven when select low and direction high
// (RULE19) qualified port-b read advances next word to output register
// (RULE20) strobe low makes select and direction irrelevant for transfers
// (RULE21) output-ready low: next word loads automatically as ready rises
// (RULE22) each flag passes two flip-flop stages on its own port clock
// (RULE23) near-empty low when count at or below near-empty offset
// (RULE24) near-full low when count at least depth minus near-full offset
// (RULE25) input-ready low: fifo writes ignored
// (RULE26) output-ready low: output register holds, fifo reads ignored
// (RULE27) programming mode stays latched until the next reset
module dcfo_fifo
	import dcfo_pkg::*;
#(
	parameter int DEPTH = 512,
	parameter int WIDTH = 36
) (
	input wire logic core_clk,
	input wire logic rst_b,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// port a, write side
	input wire logic write_side_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_direction,
	input wire logic port_a_strobe,
	input wire logic port_a_mailbox_sel,
	input wire logic [WIDTH-1:0] port_a_data_in,
	output logic [WIDTH-1:0] port_a_data_out,
	output logic port_a_data_oe,
	// port b, read side
	input wire logic read_side_clock,
	input wire logic port_b_select_n,
	input wire logic port_b_direction,
	input wire logic port_b_strobe,
	input wire logic port_b_mailbox_sel,
	input wire logic [WIDTH-1:0] port_b_data_in,
	output logic [WIDTH-1:0] port_b_data_out,
	output logic port_b_data_oe,
	// offset programming pins, also serial load bit and enable
	input wire logic flag_sel0,
	input wire logic flag_sel1,
	// flags
	output logic input_ready,
	output logic output_ready,
	output logic near_empty_n,
	output logic near_full_n,
	output logic mail1_flag_n,
	output logic mail2_flag_n
);
	// address width, serial bit count and depth at pointer width
	localparam int AW = $clog2(DEPTH);
	localparam int SBITS = 2 * AW;
	localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	dcfo_port_type pa_s1, pa_s2, pb_s1, pb_s2;
	logic pa_clk_s3, pb_clk_s3;
	logic [WIDTH-1:0] pa_data_s1, pa_data_s2;
	logic [1:0] fsel_s1, fsel_s2;
	dcfo_port_type pa_raw, pb_raw;
	// idle pin picture: deselected, clock seen high so no false edge follows reset
	localparam dcfo_port_type PIN_IDLE = '{clk: 1'b1, select_n: 1'b1, direction: 1'b0, strobe: 1'b0,
		mailbox_sel: 1'b0};
	assign pa_raw = '{write_side_clock, port_a_select_n, port_a_direction, port_a_strobe,
		port_a_mailbox_sel};
	assign pb_raw = '{read_side_clock, port_b_select_n, port_b_direction, port_b_strobe,
		port_b_mailbox_sel};

	// two stages on every port control pin
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pa_s1 <= PIN_IDLE;
			pa_s2 <= PIN_IDLE;
			pb_s1 <= PIN_IDLE;
			pb_s2 <= PIN_IDLE;
		end else begin
			pa_s1 <= pa_raw;
			pa_s2 <= pa_s1;
			pb_s1 <= pb_raw;
			pb_s2 <= pb_s1;
		end
	end

	// third stage on the clocks for edge detect, starting high like the idle picture
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pa_clk_s3 <= 1'b1;
			pb_clk_s3 <= 1'b1;
		end else begin
			pa_clk_s3 <= pa_s2.clk;
			pb_clk_s3 <= pb_s2.clk;
		end
	end

	// two stages on the write data and the flag selects
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pa_data_s1 <= '0;
			pa_data_s2 <= '0;
			fsel_s1 <= 2'h0;
			fsel_s2 <= 2'h0;
		end else begin
			pa_data_s1 <= port_a_data_in;
			pa_data_s2 <= pa_data_s1;
			fsel_s1 <= {flag_sel1, flag_sel0};
			fsel_s2 <= fsel_s1;
		end
	end

	// port clock rising edges become one-cycle enables
	wire wr_edge = pa_s2.clk & ~pa_clk_s3;
	wire rd_edge = pb_s2.clk & ~pb_clk_s3;
	wire serial_load_bit = fsel_s2[0];
	wire serial_load_en_n = fsel_s2[1];

	// ----------------------------------------
	// start-up and offset programming
	// ----------------------------------------
	// offset programming state
	dcfo_state_type state_reg;
	dcfo_mode_type mode_reg;
	logic [2:0] wr_edges_reg, rd_edges_reg;
	logic [AW-1:0] x_reg, y_reg;
	logic [$clog2(SBITS+1)-1:0] sbit_cnt_reg;
	logic [1:0] par_cnt_reg;
	logic ctrl_wen_reg;

	// transfer qualification and offset load steering
	localparam logic [2:0] EDGES = 3'(`DCFO_RESET_EDGES);
	wire edges_done = (wr_edges_reg == EDGES) && (rd_edges_reg == EDGES);
	wire [AW-1:0] preset_val = (fsel_s2 == 2'b10) ? AW'(`DCFO_PRESET_HI) : AW'(`DCFO_PRESET_LO);
	wire wr_sel = !pa_s2.select_n && !pa_s2.mailbox_sel && pa_s2.direction && pa_s2.strobe; // RULE20
	wire wr_qual = wr_edge && wr_sel && input_ready && ctrl_wen_reg; // RULE25
	wire par_load = wr_qual && (mode_reg == DCFO_MODE_PARALLEL) && (par_cnt_reg != 2'h2);
	wire mem_write = wr_qual && !par_load; // RULE17
	wire sdone = (sbit_cnt_reg == ($bits(sbit_cnt_reg))'(SBITS - 1)); // RULE13

	// edge counting and mode capture after reset release
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin // RULE2
			state_reg <= DCFO_ST_RESET;
			mode_reg <= DCFO_MODE_PARALLEL;
			wr_edges_reg <= 3'h0;
			rd_edges_reg <= 3'h0;
			sbit_cnt_reg <= '0;
		end else begin
			if (wr_edge && wr_edges_reg != EDGES)
				wr_edges_reg <= wr_edges_reg + 3'h1; // RULE1
			if (rd_edge && rd_edges_reg != EDGES)
				rd_edges_reg <= rd_edges_reg + 3'h1; // RULE1
			unique case (state_reg)
				DCFO_ST_RESET: if (edges_done) begin
					mode_reg <= dcfo_mode_type'(fsel_s2); // RULE7 RULE27
					state_reg <= (fsel_s2 == 2'b11) ? DCFO_ST_SERIAL : DCFO_ST_RUN;
				end
				DCFO_ST_SERIAL: if (wr_edge && !serial_load_en_n) begin
					sbit_cnt_reg <= sbit_cnt_reg + 1'b1;
					if (sdone)
						state_reg <= DCFO_ST_RUN; // RULE15
				end
				DCFO_ST_RUN: ;
				default: state_reg <= DCFO_ST_RESET;
			endcase
		end
	end

	// offset registers: preset, parallel or serial
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			x_reg <= '0;
			y_reg <= '0;
			par_cnt_reg <= 2'h0;
		end else if (state_reg == DCFO_ST_RESET && edges_done && fsel_s2[1] != fsel_s2[0]) begin
			x_reg <= preset_val; // RULE8
			y_reg <= preset_val;
		end else if (state_reg == DCFO_ST_SERIAL && wr_edge && !serial_load_en_n) begin
			{y_reg, x_reg} <= {y_reg[AW-2:0], x_reg, serial_load_bit}; // RULE12 RULE14
		end else if (par_load) begin
			par_cnt_reg <= par_cnt_reg + 2'h1; // RULE9
			if (par_cnt_reg == 2'h0)
				y_reg <= pa_data_s2[AW-1:0]; // RULE10
			else
				x_reg <= pa_data_s2[AW-1:0];
		end
	end

	// ----------------------------------------
	// memory and pointers
	// ----------------------------------------
	// storage and pointers, one spare bit to tell full from empty
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_reg, rptr_reg;
	logic [AW:0] wptr_r1, wptr_r2, rptr_w1, rptr_w2;
	// fill levels: core view, write-side view, read-side view
	wire [AW:0] count = wptr_reg - rptr_reg;
	wire [AW:0] count_wr = wptr_reg - rptr_w2;
	wire [AW:0] count_rd = wptr_r2 - rptr_reg;

	// memory write, no reset on the array
	always_ff @(posedge core_clk) begin
		if (mem_write)
			mem[wptr_reg[AW-1:0]] <= pa_data_s2;
	end

	// each pointer seen by the other port through two port-clock stages
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin // RULE3
			wptr_r1 <= '0;
			wptr_r2 <= '0;
			rptr_w1 <= '0;
			rptr_w2 <= '0;
		end else begin
			if (rd_edge) begin
				wptr_r1 <= wptr_reg; // RULE22
				wptr_r2 <= wptr_r1;
			end
			if (wr_edge) begin
				rptr_w1 <= rptr_reg; // RULE22
				rptr_w2 <= rptr_w1;
			end
		end
	end

	// ----------------------------------------
	// write side: pointer, input-ready, near-full
	// ----------------------------------------
	logic ir_s1, af_s1;
	// raw flag conditions ahead of the two port-clock stages
	wire ir_raw = (state_reg == DCFO_ST_RUN) && (count_wr < DEPTH_W);
	wire af_raw = count_wr < (DEPTH_W - {1'b0, y_reg}); // RULE24

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin // RULE3
			wptr_reg <= '0;
			ir_s1 <= 1'b0;
			input_ready <= 1'b0;
			af_s1 <= 1'b1;
			near_full_n <= 1'b1;
		end else begin
			if (mem_write)
				wptr_reg <= wptr_reg + 1'b1;
			if (wr_edge) begin
				ir_s1 <= ir_raw && !(mem_write && count_wr == DEPTH_W - 1'b1);
				input_ready <= ir_s1 && !(mem_write && count_wr >= DEPTH_W - 2'd2); // RULE5 RULE8 RULE22
				af_s1 <= af_raw;
				near_full_n <= af_s1;
			end
		end
	end

	// ----------------------------------------
	// read side: output register, output-ready, near-empty
	// ----------------------------------------
	logic ae_s1;
	// read qualification and output register advance
	wire rd_sel = !pb_s2.select_n && !pb_s2.mailbox_sel && pb_s2.direction && pb_s2.strobe; // RULE20
	wire rd_qual = rd_sel && output_ready; // RULE26
	wire word_avail = (count_rd != '0);
	wire advance = rd_edge && (!output_ready || rd_qual) && word_avail; // RULE21
	wire ae_raw = count > {1'b0, x_reg}; // RULE23

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin // RULE3
			rptr_reg <= '0;
			output_ready <= 1'b0;
			port_b_data_out <= '0;
			ae_s1 <= 1'b0;
			near_empty_n <= 1'b0;
		end else begin
			if (advance) begin
				port_b_data_out <= mem[rptr_reg[AW-1:0]]; // RULE19
				rptr_reg <= rptr_reg + 1'b1;
				output_ready <= 1'b1;
			end else if (rd_edge && rd_qual) begin
				output_ready <= 1'b0;
			end
			if (rd_edge) begin
				ae_s1 <= ae_raw; // RULE22
				near_empty_n <= ae_s1;
			end
		end
	end

	// ----------------------------------------
	// data bus drive and mailbox flags
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_a_data_oe <= 1'b0;
			port_b_data_oe <= 1'b0;
			port_a_data_out <= '0;
			mail1_flag_n <= 1'b1; // RULE4
			mail2_flag_n <= 1'b1; // RULE4
		end else begin
			port_a_data_oe <= !pa_s2.select_n && !pa_s2.direction; // RULE16
			port_b_data_oe <= !pb_s2.select_n && pb_s2.direction; // RULE18
			port_a_data_out <= '0;
			mail1_flag_n <= 1'b1;
			mail2_flag_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------
	logic dp_write_reg;
	logic [7:0] dp_addr_reg;
	wire ap_valid = hsel && hready && htrans[1];
	// address decode
	wire in_page = (haddr[31:8] == 24'h0);
	wire ctrl_hit = (haddr[7:0] == `DCFO_CTRL_OFS);
	wire status_hit = (haddr[7:0] == `DCFO_STATUS_OFS);
	wire offsets_hit = (haddr[7:0] == `DCFO_OFFSETS_OFS);
	wire count_hit = (haddr[7:0] == `DCFO_COUNT_OFS);
	// status: state, mode, then the four levels from near-full down to input-ready
	wire [31:0] status_word = {24'h0, state_reg, mode_reg,
		near_full_n, near_empty_n, output_ready, input_ready};
	wire [31:0] offsets_word = (32'(y_reg) << `DCFO_OFS_Y_LSB) | 32'(x_reg);
	wire [31:0] rd_mux =
		ctrl_hit ? {31'h0, ctrl_wen_reg} :
		status_hit ? status_word :
		offsets_hit ? offsets_word :
		count_hit ? 32'(count) : 32'h0;

	// address phase latch, read data registered for the data phase
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrl_wen_reg <= 1'b1;
		end else begin
			dp_write_reg <= ap_valid && hwrite && in_page;
			dp_addr_reg <= haddr[7:0];
			if (ap_valid && !hwrite)
				hrdata <= in_page ? rd_mux : 32'h0;
			if (dp_write_reg && dp_addr_reg == `DCFO_CTRL_OFS)
				ctrl_wen_reg <= hwdata[`DCFO_CTRL_WEN_BIT];
		end
	end
endmodule : dcfo_fifo

// ### shared/dcfo_defines.svh
// constants of the dual clock fifo with offset load
`ifndef DCFO_DEFINES_SVH
`define DCFO_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCFO_CTRL_OFS 8'h00
`define DCFO_STATUS_OFS 8'h04
`define DCFO_OFFSETS_OFS 8'h08
`define DCFO_COUNT_OFS 8'h0C
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DCFO_CTRL_WEN_BIT 0
`define DCFO_CTRL_RST_VAL 32'h0000_0001
`define DCFO_OFS_Y_LSB 16
// ----------------------------------------
// presets and timing counts
// ----------------------------------------
`define DCFO_PRESET_HI 64
`define DCFO_PRESET_LO 8
`define DCFO_RESET_EDGES 4
`endif

// ### shared/dcfo_pkg.sv
// types of the dual clock fifo with offset load
package dcfo_pkg;
	// offset programming mode, caught from the flag selects
	typedef enum logic [1:0] {
		DCFO_MODE_PARALLEL = 2'b00,
		DCFO_MODE_PRESET8 = 2'b01,
		DCFO_MODE_PRESET64 = 2'b10,
		DCFO_MODE_SERIAL = 2'b11
	} dcfo_mode_type;
	// start-up sequence
	typedef enum logic [1:0] {
		DCFO_ST_RESET = 2'b00,
		DCFO_ST_SERIAL = 2'b01,
		DCFO_ST_RUN = 2'b10
	} dcfo_state_type;
	// one port's control pins
	typedef struct packed {
		logic clk;
		logic select_n;
		logic direction;
		logic strobe;
		logic mailbox_sel;
	} dcfo_port_type;
endpackage : dcfo_pkg

// ### verif/dcfo_fifo_checker.sv
// pin assertions for the dual clock fifo
`timescale 1ns/1ps
module dcfo_fifo_checker
	import dcfo_pkg::*;
#(
	parameter int WIDTH = 36
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic port_a_select_n,
	input wire logic port_a_direction,
	input wire logic port_a_data_oe,
	input wire logic port_b_select_n,
	input wire logic port_b_direction,
	input wire logic port_b_data_oe,
	input wire logic [WIDTH-1:0] port_b_data_out,
	input wire logic input_ready,
	input wire logic output_ready,
	input wire logic near_empty_n,
	input wire logic near_full_n,
	input wire logic mail1_flag_n,
	input wire logic mail2_flag_n
);
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	reset_flags_a: assert property ($rose(rst_b) |-> !input_ready && !output_ready && !near_empty_n && near_full_n)
		else $error("flags wrong on reset release");
	mail_idle_a: assert property ($rose(rst_b) |-> mail1_flag_n && mail2_flag_n)
		else $error("mail flags low on reset release");
	ir_wait_a: assert property ($rose(rst_b) |-> !input_ready [*8])
		else $error("input ready too early");
	a_drive_a: assert property ((!port_a_select_n && !port_a_direction) [*4] |-> port_a_data_oe)
		else $error("port a bus not driven");
	a_float_a: assert property ((port_a_select_n || port_a_direction) [*4] |-> !port_a_data_oe)
		else $error("port a bus driven");
	b_drive_a: assert property ((!port_b_select_n && port_b_direction) [*4] |-> port_b_data_oe)
		else $error("port b bus not driven");
	b_float_a: assert property ((port_b_select_n || !port_b_direction) [*4] |-> !port_b_data_oe)
		else $error("port b bus driven");
	out_hold_a: assert property (!output_ready && !$past(output_ready) |-> $stable(port_b_data_out))
		else $error("output word moved while not ready");
endmodule : dcfo_fifo_checker
bind dcfo_fifo dcfo_fifo_checker #(.WIDTH(WIDTH)) dcfo_fifo_checker_i (.core_clk, .rst_b, .port_a_select_n,
	.port_a_direction, .port_a_data_oe, .port_b_select_n, .port_b_direction, .port_b_data_oe, .port_b_data_out,
	.input_ready, .output_ready, .near_empty_n, .near_full_n, .mail1_flag_n, .mail2_flag_n);

// ### verif/dcfo_port_host.sv
// model of the writing host on port a and the reading host on port b
`timescale 1ns/1ps
module dcfo_port_host (
	input wire logic rst_b,
	input wire logic input_ready,
	input wire logic [35:0] wr_base,
	input wire logic [15:0] wr_total,
	input wire logic rd_on,
	output logic write_side_clock,
	output logic read_side_clock,
	output logic port_a_select_n,
	output logic port_a_direction,
	output logic port_a_strobe,
	output logic [35:0] port_a_data,
	output logic port_b_select_n,
	output logic port_b_direction,
	output logic port_b_strobe,
	output logic [15:0] wr_count
);
	logic a_hit;
	logic [15:0] sent;
	// free running port clocks, unrelated to the core clock
	initial begin
		write_side_clock = 1'b0;
		#3;
		forever #40 write_side_clock = ~write_side_clock;
	end
	initial begin
		read_side_clock = 1'b0;
		#7;
		forever #48 read_side_clock = ~read_side_clock;
	end
	assign sent = wr_count + 16'(a_hit);
	// released bus shows the inverted word
	assign port_a_data = port_a_direction ? wr_base + 36'(wr_count) : ~(wr_base + 36'(wr_count));
	// a word counts as taken only while input ready was high
	always_ff @(posedge write_side_clock or negedge rst_b) begin
		if (!rst_b) a_hit <= 1'b0;
		else a_hit <= port_a_strobe && input_ready;
	end
	// pins move mid-cycle, clear of the core's late sampling
	always_ff @(negedge write_side_clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_count <= 16'h0;
			port_a_strobe <= 1'b0;
			port_a_direction <= 1'b0;
			port_a_select_n <= 1'b1;
		end else begin
			port_a_select_n <= (wr_total == 16'h0);
			wr_count <= sent;
			port_a_strobe <= sent < wr_total;
			port_a_direction <= sent < wr_total;
		end
	end
	always_ff @(negedge read_side_clock or negedge rst_b) begin
		if (!rst_b) begin
			port_b_strobe <= 1'b0;
			port_b_select_n <= 1'b1;
			port_b_direction <= 1'b0;
		end else begin
			port_b_strobe <= rd_on;
			port_b_select_n <= !rd_on;
			port_b_direction <= rd_on;
		end
	end
endmodule : dcfo_port_host

// ### verif/tb_top.sv
// self-checking bench of the dual clock fifo
`timescale 1ns/1ps
`include "dcfo_defines.svh"
module tb_top;
	logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp, flag_sel0, flag_sel1, rd_on;
	logic write_side_clock, read_side_clock, port_a_select_n, port_a_direction, port_a_strobe, port_a_data_oe;
	logic port_b_select_n, port_b_direction, port_b_strobe, port_b_data_oe;
	logic input_ready, output_ready, near_empty_n, near_full_n, mail1_flag_n, mail2_flag_n;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [35:0] port_a_data, port_a_data_out, port_b_data_out, wr_base, exp_rd;
	logic [15:0] wr_total, wr_count;
	int bad_count, checks, cycles;
	dcfo_fifo dcfo_fifo_i (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
		.hrdata, .hreadyout, .hresp, .write_side_clock, .port_a_select_n, .port_a_direction, .port_a_strobe,
		.port_a_mailbox_sel(1'b0), .port_a_data_in(port_a_data_oe ? port_a_data_out : port_a_data), .port_a_data_out,
		.port_a_data_oe, .read_side_clock, .port_b_select_n, .port_b_direction, .port_b_strobe,
		.port_b_mailbox_sel(1'b0), .port_b_data_in(36'h0), .port_b_data_out, .port_b_data_oe, .flag_sel0, .flag_sel1,
		.input_ready, .output_ready, .near_empty_n, .near_full_n, .mail1_flag_n, .mail2_flag_n);
	dcfo_port_host dcfo_port_host_i (.rst_b, .input_ready, .wr_base, .wr_total, .rd_on, .write_side_clock,
		.read_side_clock, .port_a_direction, .port_a_strobe, .port_a_data, .port_b_select_n, .port_b_direction,
		.port_b_strobe, .wr_count, .port_a_select_n);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			$display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
			bad_count++;
		end
	endtask : chk
	// one single ahb-lite transfer, waiting on hready in both phases
	task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, addr};
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic do_reset(input logic [1:0] fs);
		@(posedge core_clk);
		rst_b <= 1'b0;
		flag_sel1 <= fs[1];
		flag_sel0 <= fs[0];
		repeat (4) @(posedge read_side_clock);
		@(posedge core_clk);
		rst_b <= 1'b1;
	endtask : do_reset
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_cycles
	// every word taken at port b follows the written sequence
	always @(posedge read_side_clock) begin
		if (rd_on && port_b_strobe && output_ready) begin
			chk(port_b_data_out, exp_rd, "read word");
			exp_rd = exp_rd + 36'h1;
		end
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("unexpected at %0t ns: run took too long", $time);
			stop_test();
		end
	end
	initial begin
		{rst_b, hsel, hwrite, htrans, haddr, hwdata, rd_on, wr_base, wr_total, exp_rd} = '0;
		{flag_sel1, flag_sel0, hsize} = 5'b10010;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		// ----------
		// presets, registers
		// ----------
		for (int m = 0; m < 2; m++) begin
			if (m == 1) do_reset(2'b01);
			@(posedge core_clk);
			chk({input_ready, output_ready, near_empty_n, near_full_n, mail1_flag_n, mail2_flag_n}, 36'h7, "reset");
			for (int n = 0; n < 300 && input_ready !== 1'b1; n++) @(posedge core_clk);
			chk(input_ready, 36'h1, "ready after preset");
			ahb(1'b0, `DCFO_STATUS_OFS, 32'h0);
			chk(rd[7:0], m ? 36'h99 : 36'hA9, "status");
			ahb(1'b0, `DCFO_OFFSETS_OFS, 32'h0);
			chk(rd, m ? 36'h0008_0008 : 36'h0040_0040, "preset offsets");
		end
		ahb(1'b0, `DCFO_CTRL_OFS, 32'h0);
		chk(rd, 36'h1, "ctrl reset");
		chk({hresp, hreadyout}, 36'h1, "bus response");
		chk(port_a_data_out, 36'h0, "port a word");
		ahb(1'b1, `DCFO_CTRL_OFS, 32'h0);
		ahb(1'b0, `DCFO_CTRL_OFS, 32'h0);
		chk(rd, 36'h0, "ctrl write");
		ahb(1'b1, `DCFO_CTRL_OFS, 32'h1);
		ahb(1'b0, 8'h10, 32'h0);
		chk(rd, 36'h0, "unmapped read");
		$display("test presets done");
		// ----------
		// serial load
		// ----------
		do_reset(2'b11);
		repeat (8) @(posedge write_side_clock);
		for (int i = 17; i >= 0; i--) begin
			@(negedge write_side_clock);
			@(posedge core_clk);
			flag_sel1 <= 1'b0;
			flag_sel0 <= 18'({9'd5, 9'd6}) >> i;
			chk(input_ready, 36'h0, "ready during serial load");
		end
		@(negedge write_side_clock);
		@(posedge core_clk);
		flag_sel1 <= 1'b1;
		flag_sel0 <= 1'b0;
		for (int n = 0; n < 60 && input_ready !== 1'b1; n++) @(posedge core_clk);
		chk(input_ready, 36'h1, "ready after serial load");
		ahb(1'b0, `DCFO_OFFSETS_OFS, 32'h0);
		chk(rd, 36'h0005_0006, "serial offsets");
		ahb(1'b0, `DCFO_STATUS_OFS, 32'h0);
		chk(rd[5:4], 36'h3, "mode kept");
		wr_base <= 36'd100;
		wr_total <= 16'd8;
		for (int n = 0; n < 2000 && wr_count !== 16'd8; n++) @(posedge core_clk);
		wait_cycles(60);
		chk({near_empty_n, near_full_n}, 36'h3, "flags at eight words");
		$display("test serial done");
		// ----------
		// parallel load, fill and drain
		// ----------
		do_reset(2'b00);
		wr_base <= 36'd505;
		wr_total <= 16'd10;
		for (int n = 0; n < 3000 && wr_count !== 16'd10; n++) @(posedge core_clk);
		wait_cycles(60);
		ahb(1'b0, `DCFO_OFFSETS_OFS, 32'h0);
		chk(rd, 36'h01F9_01FA, "parallel offsets");
		chk({near_empty_n, near_full_n}, 36'h0, "flags near full");
		exp_rd = 36'd507;
		rd_on <= 1'b1;
		for (int n = 0; n < 3000 && exp_rd !== 36'd515; n++) @(posedge core_clk);
		wait_cycles(60);
		chk({output_ready, near_full_n, exp_rd}, {2'b01, 36'd515}, "drained");
		rd_on <= 1'b0;
		$display("test parallel done");
		stop_test();
	end
endmodule : tb_top
